// File: rtl/smb_slave.sv
// Serial-bus slave front end: address select, pointer, registers, alert
// Operation
// - Address-enable strap high at power-up gives address 0x2E, select ignored.
// - Address-enable strap low: select low gives 0x2C, high gives 0x2D.
// - Slave address is seven bits, compared with first seven bits after start.
// - Address latched on first matching transaction at rise of eighth clock.
// - After start, eight bits are shifted in MSB first: address then direction.
// - On match, SDA is pulled low in the low period before pulse nine.
// - On mismatch, the slave drives nothing until the next start.
// - Direction bit 0 is master write, 1 is master read.
// - First data byte of any write goes into the address pointer.
// - The address pointer selects the register for later reads and writes.
// - Once started, channels are measured in fixed order into value registers.
// - Out-of-limit results set status bits readable over the bus.
// - Mask bits keep individual status events off the alert output.
// - With alert enabled, alert goes low while any unmasked status bit is set.
// - Each temperature reading gets a signed per-channel offset added.
// - Apart from the address straps, all control and programming reaches the block only over the serial bus.
// - A second written data byte goes into the register the pointer selects.
// - A read returns the pointed register without a new pointer write.
`timescale 1ns/1ps
`default_nettype none
`include "smb_defs.svh"
module smb_slave (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap_enable,
  input wire logic addr_strap_select,
  input wire logic [8*`SMB_NCH-1:0] sample,
  output logic alert_out,
  output logic alert_oe,
  output logic [6:0] slave_addr,
  output logic addr_locked
);
  import smb_pkg::*;
  smb_line_s line;
  smb_state_e state_q, state_d;
  logic [1:0] strap_en_q;
  logic [1:0] strap_sel_q;
  logic strap_ok_q;
  logic [6:0] addr_q;
  logic locked_q;
  logic [2:0] bit_q;
  smb_byte_t shift_q;
  logic rd_q;
  logic first_q;
  logic [`SMB_PTR_W-1:0] ptr_q;
  smb_byte_t regs_q [`SMB_NREGS];
  smb_byte_t tx_q;
  logic drive_q;
  logic master_ack_q;
  logic ack_slot_q;
  logic [`SMB_NCH-1:0] status_q;
  logic [8*`SMB_NCH-1:0] value;
  logic [8*`SMB_NCH-1:0] lim_lo;
  logic [8*`SMB_NCH-1:0] lim_hi;
  logic [8*`SMB_NCH-1:0] offset;
  logic [`SMB_NCH-1:0] out_of_limit;

  smb_line_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .line(line)
  );

  // Limits and offsets come from the register file, so the bus is the only way in
  genvar gi;
  generate
    for (gi = 0; gi < `SMB_NCH; gi++) begin : g_ch
      assign lim_lo[8*gi +: 8] = regs_q[`SMB_RA_LIMLO0 + gi];
      assign lim_hi[8*gi +: 8] = regs_q[`SMB_RA_LIMHI0 + gi];
      assign offset[8*gi +: 8] = regs_q[`SMB_RA_OFS0 + gi];
    end
  endgenerate

  smb_monitor u_mon (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(regs_q[`SMB_RA_CONFIG][`SMB_CFG_START]),
    .sample(sample),
    .lim_lo(lim_lo),
    .lim_hi(lim_hi),
    .offset(offset),
    .value(value),
    .out_of_limit(out_of_limit),
    .channel()
  );

  // Strap pins are off-domain, so two flops before use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strap_en_q <= 2'h0;
      strap_sel_q <= 2'h0;
    end else begin
      strap_en_q <= {strap_en_q[0], addr_strap_enable};
      strap_sel_q <= {strap_sel_q[0], addr_strap_select};
    end
  end

  // Address selection from the synchronised straps
  function automatic logic [6:0] pick_addr(input logic en, input logic sel);
    if (en) begin
      return `SMB_ADDR_DEFAULT;
    end
    return sel ? `SMB_ADDR_SEL_HI : `SMB_ADDR_SEL_LO;
  endfunction : pick_addr

  // Straps track until the first match, then freeze; the sync pipeline needs two edges
  wire [6:0] strap_addr = pick_addr(strap_en_q[1], strap_sel_q[1]);
  wire [6:0] own_addr = locked_q ? addr_q : strap_addr;
  wire addr_match = (shift_q[6:0] == own_addr);
  wire eighth_rise = (state_q == SMB_ADDR) && line.scl_rise && (bit_q == `SMB_BIT_LAST);
  wire addr_last = line.scl_rise && (bit_q == `SMB_BIT_LAST);
  wire [7:0] byte_in = {shift_q[6:0], line.sda};

  // Read data mux: status, values, else the plain register (mask included)
  wire smb_byte_t rd_data =
    (ptr_q == `SMB_RA_STATUS) ? smb_byte_t'(status_q) :
    (ptr_q >= `SMB_RA_VAL0 && ptr_q <= `SMB_RA_VAL3) ?
      value[8*(ptr_q - `SMB_RA_VAL0) +: 8] : regs_q[ptr_q];

  // Protocol phase sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SMB_IDLE: state_d = SMB_IDLE;
      SMB_ADDR: if (addr_last) begin
        state_d = (byte_in[7:1] == own_addr) ? SMB_AACK : SMB_IDLE;
      end
      SMB_AACK: if (line.scl_fall && drive_q) begin
        state_d = rd_q ? SMB_RTX : SMB_WRX;
      end
      SMB_WRX: if (addr_last) begin
        state_d = SMB_WACK;
      end
      SMB_WACK: if (line.scl_fall && drive_q) begin
        state_d = SMB_WRX;
      end
      SMB_RTX: if (line.scl_rise && ack_slot_q && line.sda) begin
        state_d = SMB_IDLE;
      end
      default: state_d = SMB_IDLE;
    endcase
    if (line.start) begin
      state_d = SMB_ADDR;
    end else if (line.stop) begin
      state_d = SMB_IDLE;
    end
  end

  // Bit counter and shifter; bits sampled on SCL rise, MSB first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= SMB_IDLE;
      bit_q <= '0;
      shift_q <= '0;
    end else begin
      state_q <= state_d;
      if (line.start || (line.scl_fall && drive_q &&
          (state_q == SMB_AACK || state_q == SMB_WACK))) begin
        bit_q <= '0;
      end else if (line.scl_rise && state_q != SMB_IDLE && !ack_slot_q) begin
        bit_q <= bit_q + 1'b1;
        shift_q <= byte_in;
      end
    end
  end

  // Master acknowledge slot after each read byte; its rise is not a data bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_slot_q <= 1'b0;
    end else if (line.start || line.stop) begin
      ack_slot_q <= 1'b0;
    end else if (state_q == SMB_RTX && addr_last && !ack_slot_q) begin
      ack_slot_q <= 1'b1;
    end else if (line.scl_rise) begin
      ack_slot_q <= 1'b0;
    end
  end

  // Address lock: eighth rise is the direction bit, 7-bit address already in
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_q <= '0;
      locked_q <= 1'b0;
    end else if (eighth_rise && !locked_q && addr_match) begin
      addr_q <= strap_addr;
      locked_q <= 1'b1;
    end
  end

  // Direction and first-byte tracking
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_q <= 1'b0;
      first_q <= 1'b0;
    end else if (state_q == SMB_ADDR && addr_last) begin
      rd_q <= line.sda;
      first_q <= 1'b1;
    end else if (state_q == SMB_WRX && addr_last) begin
      first_q <= 1'b0;
    end
  end

  // Pointer and register writes; pointer survives repeated start
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ptr_q <= '0;
      for (int i = 0; i < `SMB_NREGS; i++) begin
        regs_q[i] <= '0;
      end
    end else if (state_q == SMB_WRX && addr_last) begin
      if (first_q) begin
        ptr_q <= byte_in[`SMB_PTR_W-1:0];
      end else begin
        regs_q[ptr_q] <= byte_in;
      end
    end
  end

  // Status bits are sticky; a new event wins over a same-cycle read clear
  wire status_rd_done = state_q == SMB_RTX && addr_last && ptr_q == `SMB_RA_STATUS;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_rd_done ? '0 : status_q) | out_of_limit;
    end
  end

  // SDA drive: set only on SCL fall so data is stable while SCL is high; start, stop or a return to idle releases it at once
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drive_q <= 1'b0;
      tx_q <= '0;
      master_ack_q <= 1'b0;
    end else if (line.start || line.stop || state_d == SMB_IDLE) begin
      drive_q <= 1'b0;
      master_ack_q <= 1'b0;
    end else if (line.scl_fall) begin
      unique case (state_q)
        SMB_AACK, SMB_WACK: begin
          drive_q <= !drive_q;
          if (drive_q && rd_q) begin
            tx_q <= rd_data;
            drive_q <= !rd_data[7];
          end
        end
        SMB_RTX: begin
          if (bit_q == '0 && master_ack_q) begin
            tx_q <= rd_data;
            drive_q <= !rd_data[7];
            master_ack_q <= 1'b0;
          end else if (bit_q == '0) begin
            drive_q <= 1'b0;
          end else begin
            drive_q <= !tx_q[`SMB_BIT_LAST - bit_q];
          end
        end
        default: begin
          drive_q <= (state_d == SMB_AACK || state_d == SMB_WACK);
        end
      endcase
    end else if (state_q == SMB_RTX && ack_slot_q && line.scl_rise && !line.sda) begin
      master_ack_q <= 1'b1;
    end
  end

  // Open-drain outputs: enable means pulling low
  wire alert_on = regs_q[`SMB_RA_CONFIG][`SMB_CFG_ALERT] &&
                  |(status_q & ~regs_q[`SMB_RA_MASK][`SMB_NCH-1:0]);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= alert_on;
    end
  end
  assign alert_out = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe = drive_q;
  assign slave_addr = own_addr;
  assign addr_locked = locked_q;
endmodule : smb_slave
`default_nettype wire

// File: rtl/smb_defs.svh
// Constants for the serial-bus slave front end of the thermal monitor
`ifndef SMB_DEFS_SVH
`define SMB_DEFS_SVH
`define SMB_ADDR_DEFAULT 7'h2e
`define SMB_ADDR_SEL_LO 7'h2c
`define SMB_ADDR_SEL_HI 7'h2d
`define SMB_BIT_LAST 3'h7
`define SMB_BIT_ADDR_LAST 3'h6
`define SMB_NREGS 32
`define SMB_PTR_W 5
`define SMB_RA_CONFIG 5'h00
`define SMB_RA_VAL0 5'h01
`define SMB_RA_VAL1 5'h02
`define SMB_RA_VAL2 5'h03
`define SMB_RA_VAL3 5'h04
`define SMB_RA_LIMLO0 5'h05
`define SMB_RA_LIMHI0 5'h09
`define SMB_RA_OFS0 5'h0d
`define SMB_RA_STATUS 5'h10
`define SMB_RA_MASK 5'h11
`define SMB_CFG_START 0
`define SMB_CFG_ALERT 1
`define SMB_NCH 4
`define SMB_CH_W 2
`define SMB_CH_LAST 2'h3
`define SMB_DWELL_NS 1000
`define SMB_CLK_NS 5
`define SMB_DWELL_CYC ((`SMB_DWELL_NS + `SMB_CLK_NS - 1) / `SMB_CLK_NS)
`define SMB_DWELL_W 8
`endif

// File: rtl/smb_pkg.sv
// Types shared by the serial-bus slave front end
package smb_pkg;
  // Conditioned bus lines after synchronisation and edge finding
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } smb_line_s;
  // Open-drain pin: drive low when enabled
  typedef struct packed {
    logic out;
    logic oe;
  } smb_od_s;
  // Protocol phases
  typedef enum logic [5:0] {
    SMB_IDLE = 6'b000001,
    SMB_ADDR = 6'b000010,
    SMB_AACK = 6'b000100,
    SMB_WRX  = 6'b001000,
    SMB_WACK = 6'b010000,
    SMB_RTX  = 6'b100000
  } smb_state_e;
  typedef logic [7:0] smb_byte_t;
endpackage : smb_pkg

// File: rtl/smb_line_sync.sv
// Two-flop synchroniser and edge / start / stop finder for the bus lines
`timescale 1ns/1ps
`default_nettype none
module smb_line_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output var smb_pkg::smb_line_s line
);
  import smb_pkg::*;
  logic [1:0] scl_q;
  logic [1:0] sda_q;
  logic scl_prev_q;
  logic sda_prev_q;
  // Second flop feeds the history flop and the edge and start/stop logic; the first is read by nothing else
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_q <= {scl_q[0], scl_in};
      sda_q <= {sda_q[0], sda_in};
      scl_prev_q <= scl_q[1];
      sda_prev_q <= sda_q[1];
    end
  end
  // Edges judged on synchronised copies; SDA change while SCL high frames the transfer
  assign line.scl_rise = scl_q[1] & ~scl_prev_q;
  assign line.scl_fall = ~scl_q[1] & scl_prev_q;
  assign line.start = scl_q[1] & scl_prev_q & sda_prev_q & ~sda_q[1];
  assign line.stop = scl_q[1] & scl_prev_q & ~sda_prev_q & sda_q[1];
  assign line.sda = sda_q[1];
endmodule : smb_line_sync
`default_nettype wire

// File: rtl/smb_monitor.sv
// Measurement sequencer: offset, value store and limit compare per channel
`timescale 1ns/1ps
`default_nettype none
`include "smb_defs.svh"
module smb_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [8*`SMB_NCH-1:0] sample,
  input wire logic [8*`SMB_NCH-1:0] lim_lo,
  input wire logic [8*`SMB_NCH-1:0] lim_hi,
  input wire logic [8*`SMB_NCH-1:0] offset,
  output logic [8*`SMB_NCH-1:0] value,
  output logic [`SMB_NCH-1:0] out_of_limit,
  output logic [`SMB_CH_W-1:0] channel
);
  import smb_pkg::*;
  logic [`SMB_DWELL_W-1:0] dwell_q;
  logic [`SMB_CH_W-1:0] ch_q;
  logic [8*`SMB_NCH-1:0] val_q;
  logic [`SMB_NCH-1:0] ool_q;
  wire dwell_done = (dwell_q == `SMB_DWELL_W'(`SMB_DWELL_CYC - 1));
  wire smb_byte_t raw = sample[8*ch_q +: 8];
  // Channel 0 is voltage with no offset; the others are temperatures
  wire smb_byte_t adj = (ch_q == '0) ? raw : raw + offset[8*ch_q +: 8];
  wire over = $signed(adj) > $signed(lim_hi[8*ch_q +: 8]);
  wire under = $signed(adj) < $signed(lim_lo[8*ch_q +: 8]);
  // Fixed round-robin with a dwell per channel
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dwell_q <= '0;
      ch_q <= '0;
      val_q <= '0;
      ool_q <= '0;
    end else if (run) begin
      dwell_q <= dwell_done ? '0 : dwell_q + 1'b1;
      if (dwell_done) begin
        ch_q <= (ch_q == `SMB_CH_LAST) ? '0 : ch_q + 1'b1;
        val_q[8*ch_q +: 8] <= adj;
        ool_q[ch_q] <= over | under;
      end
    end else begin
      dwell_q <= '0;
      ool_q <= '0;
    end
  end
  assign value = val_q;
  assign out_of_limit = ool_q;
  assign channel = ch_q;
endmodule : smb_monitor
`default_nettype wire

// File: bench/smb_master_model.sv
// Behavioural bus master: drives the clock line and pulls the data line low
`timescale 1ns/1ps
`default_nettype none
module smb_master_model (
  input wire logic ref_clk,
  input wire logic sda,
  output var logic scl,
  output var logic pull
);
  // Idle bus: clock high, data released to its pull-up
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Quarter of a 160 ns bus period; clock stands still outside frames
  task automatic q();
    repeat (8) @(negedge ref_clk);
  endtask : q
  // Also serves as a repeated start, since it first raises both lines
  task automatic start();
    pull = 1'b0;
    q();
    scl = 1'b1;
    q();
    pull = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask : start
  task automatic stop();
    pull = 1'b1;
    q();
    scl = 1'b1;
    q();
    pull = 1'b0;
    q();
  endtask : stop
  // Data changes only while the clock is low; sampled mid high period
  task automatic bit_io(input logic b, output logic r);
    pull = ~b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask : bit_io
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : recv
endmodule : smb_master_model
`default_nettype wire

// File: bench/smb_slave_chk.sv
// Port-level checks of the serial-bus slave
`timescale 1ns/1ps
`default_nettype none
`include "smb_defs.svh"
module smb_slave_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic addr_strap_enable,
  input wire logic addr_strap_select,
  input wire logic [8*`SMB_NCH-1:0] sample,
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic [6:0] slave_addr,
  input wire logic addr_locked
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Start seen at the pins, then the slave keeps off the line
  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  sequence s_quiet;
    !sda_oe [*8];
  endsequence
  AST_ADDR_DEFAULT: assert property ((addr_strap_enable && !addr_locked) [*4] |->
    slave_addr == `SMB_ADDR_DEFAULT) else $error("default address not in force");
  AST_ADDR_SEL: assert property ((!addr_strap_enable && !addr_locked
    && $stable(addr_strap_select)) [*4] |-> slave_addr == {6'h16, addr_strap_select})
    else $error("strap address wrong");
  AST_LOCK_STICKY: assert property (addr_locked |=> addr_locked && $stable(slave_addr))
    else $error("latched address moved");
  AST_LOCK_AT_RISE: assert property ($rose(addr_locked) |-> scl_in)
    else $error("address latched outside clock high");
  AST_LOCK_ACK: assert property ($rose(addr_locked) |-> ##[1:64] sda_oe)
    else $error("no acknowledge after match");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed with clock high");
  AST_ACK_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("drive too short");
  AST_START_QUIET: assert property (s_start |-> s_quiet)
    else $error("slave drove during address phase");
  AST_OD_LOW: assert property (!sda_out && !alert_out)
    else $error("open-drain value not low");
endmodule : smb_slave_chk
bind smb_slave smb_slave_chk chk_i (.ref_clk(ref_clk), .rst(rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_enable(addr_strap_enable),
  .addr_strap_select(addr_strap_select), .sample(sample), .alert_out(alert_out),
  .alert_oe(alert_oe), .slave_addr(slave_addr), .addr_locked(addr_locked));
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the serial-bus slave front end
`timescale 1ns/1ps
`default_nettype none
`include "smb_defs.svh"
module tb_top;
  localparam logic [6:0] DEV_A = `SMB_ADDR_DEFAULT;
  logic ref_clk, rst, en, sel, pull, scl, sda_oe, alert_oe, locked;
  logic [6:0] sa;
  logic [4:0] ptr;
  logic [7:0] mdl [32];
  logic [8*`SMB_NCH-1:0] sample;
  wire logic sda;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  // Pulled-up data line: low while either party drives it
  assign sda = ~(pull | sda_oe);
  smb_master_model m (.ref_clk(ref_clk), .sda(sda), .scl(scl), .pull(pull));
  smb_slave uut (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .addr_strap_enable(en), .addr_strap_select(sel), .sample(sample),
    .alert_out(), .alert_oe(alert_oe), .slave_addr(sa), .addr_locked(locked));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Run needs about 25k cycles; more than twice that means a hang
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // Straps settle the address through the two-flop sync after reset is released
  task automatic rs(input logic e, input logic s);
    @(negedge ref_clk);
    rst = 1'b1;
    en = e;
    sel = s;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask : rs
  // Pointer byte, then a data byte when d is not negative
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input int d, input logic ack_e);
    logic k;
    m.start();
    m.send({a, 1'b0}, k);
    chk({7'h0, k}, {7'h0, ack_e});
    if (k) begin
      m.send(p, k);
      ptr = p[4:0];
      if (d >= 0) begin
        m.send(d[7:0], k);
        mdl[ptr] = d[7:0];
      end
    end
    m.stop();
  endtask : wr
  // Optional pointer write, then a repeated start and a one-byte read
  task automatic rd(input int p, output logic [7:0] v);
    logic k;
    m.start();
    if (p >= 0) begin
      m.send({DEV_A, 1'b0}, k);
      m.send(p[7:0], k);
      ptr = p[4:0];
      m.start();
    end
    m.send({DEV_A, 1'b1}, k);
    chk({7'h0, k}, 8'h01);
    m.recv(1'b1, v);
    m.stop();
  endtask : rd
  initial begin
    logic [7:0] v, s0, s1;
    logic [7:0] wl [4];
    rst = 1'b1;
    en = 1'b1;
    sel = 1'b0;
    sample = '0;
    wl = '{8'h06, 8'h0a, 8'h0f, 8'h11};
    void'($urandom(32'h55bd));
    rs(1'b1, 1'($urandom));
    chk({1'b0, sa}, {1'b0, DEV_A});
    wr(`SMB_ADDR_SEL_LO, 8'h05, -1, 1'b0);
    chk({7'h0, locked}, 8'h00);
    wr(DEV_A, 8'h05, -1, 1'b1);
    en = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk({7'h0, locked}, 8'h01);
    chk({1'b0, sa}, {1'b0, DEV_A});
    // Round trip; upper pointer bits are random and must be dropped
    foreach (wl[i]) begin
      wr(DEV_A, {3'($urandom), wl[i][4:0]}, int'($urandom % 256), 1'b1);
      rd(wl[i], v);
      chk(v, mdl[wl[i][4:0]]);
    end
    wr(DEV_A, wl[0], -1, 1'b1);
    rd(-1, v);
    chk(v, mdl[wl[0][4:0]]);
    s0 = 8'h20 + 8'($urandom % 64);
    s1 = 8'h20 + 8'($urandom % 64);
    sample = {16'($urandom), s1, s0};
    wr(DEV_A, 8'h05, 0, 1'b1);
    wr(DEV_A, 8'h09, 8'h10, 1'b1);
    wr(DEV_A, 8'h0e, 8'hfe, 1'b1);
    wr(DEV_A, 8'h11, 8'hff, 1'b1);
    wr(DEV_A, 8'h00, 8'h03, 1'b1);
    repeat (1000) @(negedge ref_clk);
    chk({7'h0, alert_oe}, 8'h00);
    rd(8'h01, v);
    chk(v, s0);
    rd(8'h02, v);
    chk(v, s1 - 8'h02);
    wr(DEV_A, 8'h01, 8'h00, 1'b1);
    rd(-1, v);
    chk(v, s0);
    wr(DEV_A, 8'h11, 8'h00, 1'b1);
    repeat (1000) @(negedge ref_clk);
    chk({7'h0, alert_oe}, 8'h01);
    // Select mode: only the strapped address answers
    for (int s = 0; s < 2; s++) begin
      rs(1'b0, s[0]);
      chk({1'b0, sa}, {1'b0, 6'h16, s[0]});
      wr({6'h16, ~s[0]}, 8'h05, -1, 1'b0);
      wr(DEV_A, 8'h05, -1, 1'b0);
      wr({6'h16, s[0]}, 8'h05, -1, 1'b1);
    end
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
